// [shared/cbu_cfg.svh]
// Constants for the conditional branch unit: field positions, flag bits and widths.
// Assumes the 16-bit jump word layout of the core and a 16-bit status word.
`ifndef CBU_CFG_SVH
`define CBU_CFG_SVH
`define CBU_PC_W 20
`define CBU_OFS_W 10
`define CBU_OFS_MSB 9
`define CBU_COND_MSB 12
`define CBU_COND_LSB 10
`define CBU_JUMP_MSB 15
`define CBU_JUMP_LSB 13
`define CBU_JUMP_TAG 3'h1
`define CBU_SR_C 0
`define CBU_SR_Z 1
`define CBU_SR_N 2
`define CBU_SR_IRQ_EN 3
`define CBU_SR_CORE_HALT 4
`define CBU_SR_OSC_OFF 5
`define CBU_SR_V 8
`define CBU_SR_RST 16'h0000
`define CBU_PC_RST 20'h00000
`define CBU_PC_STEP 20'h00002
`endif

// [shared/cbu_pkg.sv]
// Types for the conditional branch unit.
// Assumes the constants of cbu_cfg.svh.
`default_nettype none
package cbu_pkg;
  // Condition codes of the relative jump group.
  typedef enum logic [2:0] {
    cbu_cond_no_carry = 3'h3,
    cbu_cond_zero = 3'h1,
    cbu_cond_no_zero = 3'h0,
    cbu_cond_carry = 3'h2,
    cbu_cond_negative = 3'h4,
    cbu_cond_signed_ge = 3'h5,
    cbu_cond_signed_lt = 3'h6,
    cbu_cond_always = 3'h7
  } cbu_cond_type;
  // One instruction handed to the unit.
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic [19:0] pc;
  } cbu_issue_type;
  // Outcome for the fetch stage.
  typedef struct packed {
    logic valid;
    logic taken;
    logic [19:0] next_pc;
  } cbu_result_type;
  typedef enum logic [1:0] {
    cbu_st_idle = 2'b01,
    cbu_st_resolve = 2'b10
  } cbu_state_type;
endpackage
`default_nettype wire

// [design/cbu_branch_unit.sv]
// Conditional branch unit: decides relative jumps and forms the next fetch address.
// Assumes the issue word comes from logic on mclk_in and the status word is the live
// register of the core, already holding the last completed instruction's flags.
// The pc that travels with the issue word is the address of the jump word itself.
//
// Behaviour
// - A taken jump doubles and sign-extends the 10-bit offset and adds it to the 20-bit fall-through address, PC + 2.
// - Targets reach from 511 words before to 512 words after the PC, wrapping over memory.
// - Jump-if-carry branches on carry set and falls through on carry clear.
// - Jump-if-no-carry branches on carry clear and falls through on carry set.
// - Unsigned higher-or-same and lower share the carry and no-carry encodings.
// - Jump-if-zero or equal branches on zero set and falls through otherwise.
// - Signed greater-or-equal branches when negative equals overflow.
// - Signed less-than branches when exactly one of negative and overflow is set.
// - The unconditional jump always loads the computed target.
// - Jump-if-negative branches on negative set and falls through otherwise.
// - No jump changes the carry, zero, negative or overflow flags.
// - No jump changes the oscillator-off, core-halt or interrupt-enable bits.
// - After an overflow-clearing instruction the signed greater-or-equal acts as positive.
// - The carry test reads the status register as it stands when the jump executes.
`timescale 1ns/1ns
`include "cbu_cfg.svh"
`default_nettype none
module cbu_branch_unit (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire cbu_pkg::cbu_issue_type issue_in,
  input wire logic [15:0] status_in,
  output logic [15:0] status_out,
  output cbu_pkg::cbu_result_type result_out
);
  // Field decode of the issued word.
  wire logic is_jump;
  wire logic [2:0] cond;
  wire logic [`CBU_OFS_W-1:0] ofs;
  wire logic flag_c;
  wire logic flag_z;
  wire logic flag_n;
  wire logic flag_v;
  wire logic cond_true;
  wire logic sel_no_zero;
  wire logic sel_zero;
  wire logic sel_carry;
  wire logic sel_no_carry;
  wire logic sel_negative;
  wire logic sel_signed_ge;
  wire logic sel_signed_lt;
  wire logic sel_always;
  wire logic ne_v;
  wire logic is_issue;
  wire logic is_taken;
  wire logic [`CBU_PC_W-1:0] ofs_bytes;
  wire logic [`CBU_PC_W-1:0] target;
  wire logic [`CBU_PC_W-1:0] fall_pc;
  cbu_pkg::cbu_result_type result_nxt;
  cbu_pkg::cbu_result_type result_r;
  logic [15:0] status_r;

  assign is_jump = issue_in.word[`CBU_JUMP_MSB:`CBU_JUMP_LSB] == `CBU_JUMP_TAG;
  assign cond = issue_in.word[`CBU_COND_MSB:`CBU_COND_LSB];
  assign ofs = issue_in.word[`CBU_OFS_MSB:0];
  // Flags are read straight from the live status word, so no wait is needed.
  assign flag_c = status_in[`CBU_SR_C];
  assign flag_z = status_in[`CBU_SR_Z];
  assign flag_n = status_in[`CBU_SR_N];
  assign flag_v = status_in[`CBU_SR_V];

  // One-hot condition decode against the package codes; higher-or-same and lower
  // share the carry and no-carry codes, so they need no encodings of their own.
  assign sel_no_zero = cond == cbu_pkg::cbu_cond_no_zero;
  assign sel_zero = cond == cbu_pkg::cbu_cond_zero;
  assign sel_carry = cond == cbu_pkg::cbu_cond_carry;
  assign sel_no_carry = cond == cbu_pkg::cbu_cond_no_carry;
  assign sel_negative = cond == cbu_pkg::cbu_cond_negative;
  assign sel_signed_ge = cond == cbu_pkg::cbu_cond_signed_ge;
  assign sel_signed_lt = cond == cbu_pkg::cbu_cond_signed_lt;
  assign sel_always = cond == cbu_pkg::cbu_cond_always;

  // Signed tests hinge on whether negative and overflow disagree; an instruction that
  // clears overflow leaves ne_v equal to the negative flag, so signed ge acts as positive.
  assign ne_v = flag_n ^ flag_v;

  // Exactly one select is high for any code, so an OR of guarded terms is enough and
  // keeps a priority chain off the flag path.
  assign cond_true =
    (sel_no_zero & !flag_z) |
    (sel_zero & flag_z) |
    (sel_carry & flag_c) |
    (sel_no_carry & !flag_c) |
    (sel_negative & flag_n) |
    (sel_signed_ge & !ne_v) |
    (sel_signed_lt & ne_v) |
    sel_always;

  // The program counter has already stepped past the jump word when the offset is
  // added, so the base is the fall-through address; that is what gives a reach of
  // 511 words back and 512 words forward from the jump word itself.
  // Offset doubled and sign-extended; the add wraps modulo 2^20 on purpose, so a
  // jump near either end of memory lands at the other end rather than saturating.
  assign fall_pc = issue_in.pc + `CBU_PC_STEP;
  assign ofs_bytes = {{(`CBU_PC_W-`CBU_OFS_W-1){ofs[`CBU_OFS_MSB]}}, ofs, 1'b0};
  assign target = fall_pc + ofs_bytes;

  // Qualified decision terms; a word that is not a jump never branches.
  assign is_issue = issue_in.valid && is_jump;
  assign is_taken = is_jump && cond_true;

  // Combined result for the fetch stage.
  always_comb begin
    result_nxt.valid = is_issue;
    result_nxt.taken = is_issue && cond_true;
    result_nxt.next_pc = is_taken ? target : fall_pc;
  end

  // Outputs registered; the status word is passed through untouched by jumps.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      result_r <= '0;
      status_r <= `CBU_SR_RST;
    end else begin
      result_r <= result_nxt;
      status_r <= status_in;
    end
  end

  // Outputs come straight from the registers above.
  assign result_out = result_r;
  assign status_out = status_r;

  // Checks on the registered answer. Each looks one edge after issue, where the answer
  // stands, and rebuilds what it expects from the raw word, the pc and the status word
  // where it can, so that a slip in the decode above cannot hide itself.

  // A taken jump lands on the fall-through address plus the doubled offset.
  a_taken_target: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond_true |=> result_out.next_pc == $past(issue_in.pc) +
      `CBU_PC_STEP + {{9{$past(issue_in.word[9])}}, $past(issue_in.word[9:0]), 1'b0})
    else $error("taken jump target wrong");

  // The target stays between 511 words back and 512 words forward, modulo memory.
  a_reach_window: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond_true |=>
      (result_out.next_pc - $past(issue_in.pc) + 20'h003fe) <= 20'h007fe)
    else $error("jump target outside reach");

  // Carry set branches on the carry code.
  a_carry_taken: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond == 3'h2 |=> result_out.taken == $past(flag_c))
    else $error("carry jump decision wrong");

  // Carry clear branches on the no-carry code.
  a_nocarry_taken: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond == 3'h3 |=> result_out.taken != $past(flag_c))
    else $error("no-carry jump decision wrong");

  // The unsigned aliases share the carry codes, so the two codes always disagree.
  a_unsigned_alias: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && (cond == 3'h2 || cond == 3'h3) |=>
      result_out.taken == ($past(status_in[`CBU_SR_C]) == ($past(cond) == 3'h2)))
    else $error("unsigned alias decision wrong");

  // Zero set branches on the zero code.
  a_zero_taken: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond == 3'h1 |=> result_out.taken == $past(flag_z))
    else $error("zero jump decision wrong");

  // Signed ge branches when negative and overflow agree.
  a_sge_taken: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond == 3'h5 |=> result_out.taken == !$past(flag_n ^ flag_v))
    else $error("signed ge decision wrong");

  // With overflow clear, signed ge follows the sign alone, as a jump on positive.
  a_positive_emul: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond == 3'h5 && !status_in[`CBU_SR_V] |=>
      result_out.taken == !$past(status_in[`CBU_SR_N]))
    else $error("positive emulation wrong");

  // Signed lt branches when exactly one of negative and overflow is set.
  a_slt_taken: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond == 3'h6 |=> result_out.taken == $past(flag_n ^ flag_v))
    else $error("signed lt decision wrong");

  // The unconditional code always branches.
  a_always_taken: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond == 3'h7 |=> result_out.taken)
    else $error("unconditional jump not taken");

  // Negative set branches on the negative code.
  a_neg_taken: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && cond == 3'h4 |=> result_out.taken == $past(flag_n))
    else $error("negative jump decision wrong");

  // A jump that is not taken continues with the word after it.
  a_fall_pc: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump && !cond_true |=>
      result_out.next_pc == $past(issue_in.pc) + 20'h00002)
    else $error("fall-through address wrong");

  // The carry decision follows the raw status word as it stands at issue.
  a_carry_live: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && issue_in.word[`CBU_JUMP_MSB:`CBU_JUMP_LSB] == `CBU_JUMP_TAG &&
      issue_in.word[`CBU_COND_MSB:`CBU_COND_LSB] == 3'h2 |=>
      result_out.taken == $past(status_in[`CBU_SR_C]))
    else $error("carry test not live");

  // Every jump is answered at the next edge, with no stall.
  a_no_stall: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump |=> result_out.valid)
    else $error("jump answer late");

  // A word that is not a jump never branches and simply steps on.
  a_nonjump_idle: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && !is_jump |=> !result_out.valid && !result_out.taken &&
      result_out.next_pc == $past(issue_in.pc) + `CBU_PC_STEP)
    else $error("non-jump word answered as jump");

  // Without an issue there is no decision.
  a_idle_quiet: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !issue_in.valid |=> !result_out.valid && !result_out.taken)
    else $error("decision without issue");

  // The whole status word is copied unchanged.
  a_status_kept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid |=> status_out == $past(status_in))
    else $error("jump altered status word");

  // The four condition flags survive a jump.
  a_flags_kept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump |=> {status_out[`CBU_SR_V], status_out[`CBU_SR_N],
      status_out[`CBU_SR_Z], status_out[`CBU_SR_C]} == $past({status_in[`CBU_SR_V],
      status_in[`CBU_SR_N], status_in[`CBU_SR_Z], status_in[`CBU_SR_C]}))
    else $error("jump altered condition flags");

  // The oscillator-off, core-halt and interrupt-enable bits survive a jump.
  a_mode_kept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    issue_in.valid && is_jump |=> {status_out[`CBU_SR_OSC_OFF],
      status_out[`CBU_SR_CORE_HALT], status_out[`CBU_SR_IRQ_EN]} ==
      $past({status_in[`CBU_SR_OSC_OFF], status_in[`CBU_SR_CORE_HALT],
      status_in[`CBU_SR_IRQ_EN]}))
    else $error("jump altered mode bits");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the branch unit: decisions, targets, status copy and reset.
// Assumes the unit answers one cycle after issue and copies the status word.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  cbu_pkg::cbu_issue_type issue_in = '0;
  logic [15:0] status_in = 16'hffff;
  logic [15:0] status_out;
  cbu_pkg::cbu_result_type result_out;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  cbu_branch_unit u_cbu_branch_unit (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .issue_in(issue_in), .status_in(status_in), .status_out(status_out),
    .result_out(result_out));
  // The clock toggles every 5 ns.
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // A hang is cut short far beyond the 140 or so cycles the tests need.
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Expected decision from the condition field and the C, Z, N and V bits.
  function automatic logic taken_f(input logic [2:0] c, input logic [15:0] s);
    case (c)
      3'h0: return !s[1];
      3'h1: return s[1];
      3'h2: return s[0];
      3'h3: return !s[0];
      3'h4: return s[2];
      3'h5: return s[2] == s[8];
      3'h6: return s[2] != s[8];
      default: return 1'b1;
    endcase
  endfunction
  // Issues one word at a falling edge and judges the answer one cycle later.
  task automatic op(input logic [15:0] w, input logic [19:0] pc, input logic [15:0] sr);
    logic v;
    logic tk;
    logic [19:0] nx;
    v = (w[15:13] == 3'h1);
    tk = v && taken_f(w[12:10], sr);
    nx = pc + 20'h00002 + (tk ? {{9{w[9]}}, w[9:0], 1'b0} : 20'h00000);
    issue_in = {1'b1, w, pc};
    status_in = sr;
    @(negedge mclk_in);
    chk("result", result_out, {v, tk, nx});
    chk("status", {6'h00, status_out}, {6'h00, sr});
  endtask
  task automatic t_conds;
    logic [15:0] sr;
    for (int c = 0; c < 8; c++) begin
      for (int f = 0; f < 16; f++) begin
        sr = {7'h00, f[3], 2'h0, {3{f[0]}}, f[2:0]};
        op({3'h1, c[2:0], 10'h0c3}, {f[3:0], 16'h1230}, sr);
      end
    end
  endtask
  task automatic t_range;
    logic [9:0] ofs[4] = '{10'h1ff, 10'h200, 10'h001, 10'h3fe};
    logic [19:0] pcs[4] = '{20'h01000, 20'h01000, 20'hffffc, 20'h00000};
    logic [19:0] tgt[4] = '{20'h01400, 20'h00c02, 20'h00000, 20'hffffe};
    for (int i = 0; i < 4; i++) begin
      op({6'h0f, ofs[i]}, pcs[i], 16'h0000);
      chk("target", {2'h0, result_out.next_pc}, {2'h0, tgt[i]});
    end
  endtask
  task automatic t_nonjump;
    logic [15:0] w[3] = '{16'h4000, 16'h0000, 16'hffff};
    for (int i = 0; i < 3; i++) begin
      op(w[i], 20'h0abc0, 16'h0107);
    end
  endtask
  // Reset in mid-run must clear both outputs at the next edge; the jump issued
  // right at release must then be answered as usual.
  task automatic t_reset;
    issue_in = {1'b1, 16'h3c05, 20'h00100};
    nrst_in = 1'b0;
    @(negedge mclk_in);
    chk("rst result", result_out, 22'h000000);
    chk("rst status", {6'h00, status_out}, 22'h000000);
    nrst_in = 1'b1;
    op(16'h3c05, 20'h00100, 16'h0000);
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence: three reset cycles, then each scenario in turn.
  initial begin
    repeat (3) @(negedge mclk_in);
    chk("init result", result_out, 22'h000000);
    nrst_in = 1'b1;
    t_conds();
    t_range();
    t_nonjump();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
